// ---- hw/esc_cmd_port.sv ----
// Drive-side serial command, select and data path control
// Operation
// R1: Opcode bits 15-12, modifier bits 11-8
// R2: Parameter bits 11-0; seek cylinder
// R3: Config modifier 0000 returns general word
// R4: Status response carries sixteen status bits
// R5: Media data bypasses command handshake lines
// R6: Address mark search while both gates low
// R7: Reference clock becomes read clock on gate
// R8: Host tracks index/sector, raises read gate
// R9: Host writes with gate and write clock
// R10: Respond only when select equals ID
// R11: Host waits one second before selecting
// R12: Selected and ready valid within 1 us
// R13: Host holds select 1 us after write
// R14: Head settled 5 us before write
// R15: Write gate low 1 us before head
// R16: Read data valid after head change
// R17: Ack toggles for each request edge
// R18: Implement listed opcodes; others are invalid
// R19: Unimplemented commands handled as invalid, not run
// R20: Host starts words only with complete high
// R21: Seek complete raises command complete
// R22: Recalibrate finishes within 100 ms
// R23: Sixteen data bits plus parity, interlocked
// R24: Attention 100 ns before complete on error
// R25: Synchronise all asynchronous host inputs first
// R26: Odd parity; mismatch is parity error
`timescale 1ns/1ns
module esc_cmd_port
	import esc_pkg::*;
#(
	parameter int RECAL_CYC = RECAL_CYC_DEF  // Recalibrate time limit
) (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	// Host select and head lines
	input  wire logic [2:0]  I_SEL,
	input  wire logic [3:0]  I_HEAD,
	input  wire logic [2:0]  I_DRIVE_ID,
	// Host command handshake
	input  wire logic        I_XFER_REQ,
	input  wire logic        I_CMD_DATA,
	// Host gates and write data
	input  wire logic        I_READ_GATE,
	input  wire logic        I_WRITE_GATE,
	input  wire logic        I_AM_ENABLE,
	input  wire logic        I_WRITE_CLK,
	input  wire logic        I_WRITE_DATA,
	// Read channel
	input  wire logic        I_READ_CLK,
	input  wire logic        I_READ_DATA,
	input  wire logic        I_REF_CLK,
	input  wire logic        I_AM_DETECT,
	// Drive mechanics and information
	input  wire logic        I_READY,
	input  wire logic        I_MOTOR_OPT,
	input  wire logic        I_FAULT,
	input  wire logic        I_SEEK_DONE,
	input  wire logic [15:0] I_INFO_WORD,
	// Host status outputs
	output logic             O_DRIVE_SELECTED,
	output logic             O_READY,
	output logic             O_CMD_COMPLETE,
	output logic             O_ATTENTION,
	output logic             O_XFER_ACK,
	output logic             O_CFG_STATUS,
	output logic             O_AM_FOUND,
	// Host data outputs
	output logic             O_READ_DATA,
	output logic             O_REF_CLK_OUT,
	// Media side
	output logic [3:0]       O_HEAD,
	output logic             O_MEDIA_WR_CLK,
	output logic             O_MEDIA_WR_DATA,
	// Mechanics requests
	output logic             O_SEEK_START,
	output logic [11:0]      O_SEEK_CYL,
	output logic             O_RECAL_START,
	output logic             O_MOTOR_START,
	output logic             O_CMD_STROBE,
	output logic [15:0]      O_CMD_WORD,
	output logic             O_INFO_KIND,
	output logic [3:0]       O_INFO_SEL
);

	// Whole state of the block
	typedef struct packed {
		esc_state_t         st;        // Command state
		logic               req_prev;  // Last request level
		logic               pend;      // Ack answer pending
		logic               ack;       // Ack level
		logic [CNT_W-1:0]   cnt;       // Shared delay counter
		logic [BITS_W-1:0]  bits;      // Bits moved this word
		logic [16:0]        shreg;     // Word plus parity
		logic               ld;        // Load reply next cycle
		logic               recal;     // Waiting on recalibrate
		logic               att;       // Attention level
		logic               f_par;     // Parity error flag
		logic               f_inv;     // Invalid command flag
		logic               cc;        // Command complete
		logic               sel;       // Selected
		logic               rdy;       // Ready seen by host
		logic               dout;      // Serial reply bit
		logic               amf;       // Address mark found
		logic               rdata;     // Read data out
		logic               refo;      // Reference clock out
		logic [3:0]         head;      // Head to media
		logic               wclk;      // Write clock to media
		logic               wdat;      // Write data to media
		logic               seek_go;   // Seek pulse
		logic [11:0]        cyl;       // Seek target
		logic               recal_go;  // Recalibrate pulse
		logic               motor_go;  // Motor start pulse
		logic               stb;       // Other command pulse
		logic [15:0]        cmd;       // Last accepted word
		logic               kind;      // Information kind
		logic [3:0]         isel;      // Information selector
	} esc_state_reg_t;

	esc_state_reg_t q;
	esc_state_reg_t d;

	// Synchronised pins
	logic [2:0] s_sel;
	logic [2:0] s_id;
	logic [3:0] s_head;
	logic       s_req, s_cdat, s_rg, s_wg, s_amen;
	logic       s_wclk, s_wdat, s_rclk, s_rdat, s_refc, s_amdet;

	// All asynchronous inputs through two flops
	esc_sync #(
		.WIDTH (21)
	) u_sync (
		.i_clk     (I_CLK),
		.i_reset_n (I_RESET_N),
		.i_async   ({I_SEL, I_DRIVE_ID, I_HEAD, I_XFER_REQ, I_CMD_DATA,
			I_READ_GATE, I_WRITE_GATE, I_AM_ENABLE, I_WRITE_CLK,
			I_WRITE_DATA, I_READ_CLK, I_READ_DATA, I_REF_CLK,
			I_AM_DETECT}),                                       // R25
		.o_sync    ({s_sel, s_id, s_head, s_req, s_cdat, s_rg, s_wg,
			s_amen, s_wclk, s_wdat, s_rclk, s_rdat, s_refc, s_amdet})
	);

	// Command validity from opcode, modifier and drive state
	function automatic logic cmd_valid(input logic [15:0] w,
		input logic rdy, input logic mopt);
		logic [3:0] op;
		logic [3:0] md;
		logic       ok;
		op = w[OP_HI:OP_LO];                                     // R1
		md = w[MOD_HI:MOD_LO];                                   // R1
		ok = 1'b0;
		unique case (op)
			OP_SEEK, OP_RECAL, OP_STROBE, OP_TRACK, OP_DIAG,
			OP_SETCFG: ok = rdy;                                 // R18
			OP_BPS:    ok = rdy && (w[PAR_HI:0] >= BPS_MIN);
			OP_STATUS: ok = 1'b1;
			OP_CONFIG: ok = (md < MOD_CFG_BADLO) ||
				(md > MOD_CFG_BADHI);                            // R19
			OP_CONTROL: ok = (md == MOD_RST_ATTN) ||
				((md == MOD_START_MTR) && mopt);                 // R18
			default:   ok = 1'b0;                                // R19
		endcase
		return ok;
	endfunction : cmd_valid

	// Next-state logic
	always_comb begin
		logic        match;
		logic        edge_seen;
		logic [15:0] rw;
		match     = 1'b0;
		edge_seen = 1'b0;
		rw        = '0;
		d         = q;
		// One-cycle pulses fall back
		d.seek_go  = 1'b0;
		d.recal_go = 1'b0;
		d.motor_go = 1'b0;
		d.stb      = 1'b0;
		// Select decode, zero never matches
		match = (s_sel == s_id) && (s_id != ID_NONE);            // R10
		d.sel = match;                                           // R12
		d.rdy = match && I_READY;                                // R12
		d.head = s_head;
		// Read path gated by select and read gate
		d.rdata = match && s_rg && s_rdat;                       // R16
		d.refo  = (match && s_rg) ? s_rclk : s_refc;             // R7
		// Write path on its own lines
		d.wclk = match && s_wg && s_wclk;                        // R5
		d.wdat = match && s_wg && s_wdat;                        // R5
		// Address mark search only with both gates low
		if (!s_amen) begin
			d.amf = 1'b0;
		end else if (match && !s_rg && !s_wg && s_amdet) begin
			d.amf = 1'b1;                                        // R6
		end
		// Request edge, taken only while words may move
		edge_seen  = (s_req != q.req_prev);
		d.req_prev = s_req;
		if (edge_seen && !q.pend && !q.ld &&
			((q.st == ST_RX) || (q.st == ST_TX) ||
			((q.st == ST_IDLE) && match))) begin
			d.pend = 1'b1;
			d.cnt  = '0;
			if (s_req) begin
				d.bits = q.bits + 1'b1;                          // R23
				if (q.st == ST_TX) begin
					d.dout  = q.shreg[WORD_BITS-1];
					d.shreg = {q.shreg[WORD_BITS-2:0], 1'b0};
				end else begin
					d.shreg = {q.shreg[WORD_BITS-2:0], s_cdat};
					d.st    = ST_RX;
				end
			end
		end
		// Ack follows request after the answer delay
		if (q.pend) begin
			if (q.cnt == CNT_W'(ACK_CYC - 1)) begin
				d.pend = 1'b0;
				d.ack  = q.req_prev;                             // R17
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
		// Command sequencing
		unique case (q.st)
			ST_IDLE: begin
				d.bits = (d.st == ST_IDLE) ? '0 : d.bits; // Keep first bit
			end
			ST_RX: begin
				// Word ends when the last ack has fallen
				if (!q.pend && !q.ack &&
					(q.bits == BITS_W'(WORD_BITS))) begin
					d.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				d.bits = '0;
				d.cnt  = '0;
				d.st   = ST_LEAD;
				rw     = q.shreg[WORD_BITS-1:1];
				if (!(^q.shreg)) begin
					// Even total is a parity error
					d.f_par = 1'b1;                              // R26
					d.att   = 1'b1;                              // R24
				end else if (!cmd_valid(rw, I_READY, I_MOTOR_OPT)) begin
					d.f_inv = 1'b1;                              // R19
					d.att   = 1'b1;                              // R24
				end else begin
					d.cmd = rw;
					unique case (rw[OP_HI:OP_LO])
						OP_SEEK: begin
							d.seek_go = 1'b1;
							d.cyl     = rw[PAR_HI:0];            // R2
							d.recal   = 1'b0;
							d.st      = ST_WAIT;                 // R21
						end
						OP_RECAL: begin
							d.recal_go = 1'b1;
							d.recal    = 1'b1;
							d.st       = ST_WAIT;                // R22
						end
						OP_STATUS, OP_CONFIG: begin
							d.kind = (rw[OP_HI:OP_LO] == OP_CONFIG) ?
								INFO_CONFIG : INFO_STATUS;       // R3
							d.isel = rw[MOD_HI:MOD_LO];          // R3
							d.ld   = 1'b1;
							d.st   = ST_TX;
						end
						OP_CONTROL: begin
							if (rw[MOD_HI:MOD_LO] == MOD_RST_ATTN) begin
								d.att   = 1'b0;
								d.f_par = 1'b0;
								d.f_inv = 1'b0;
							end else begin
								d.motor_go = 1'b1;
							end
						end
						OP_DIAG: begin
							d.att = I_FAULT;                     // R24
						end
						default: begin
							d.stb = 1'b1;
						end
					endcase
				end
			end
			ST_TX: begin
				if (q.ld) begin
					// Reply word with own flags in standard status
					rw = I_INFO_WORD;                            // R4
					if ((q.kind == INFO_STATUS) &&
						(q.isel == MOD_GENERAL)) begin
						rw[STS_PARITY]  = rw[STS_PARITY] | q.f_par;
						rw[STS_INVALID] = rw[STS_INVALID] | q.f_inv;
					end
					d.shreg = {rw, ~(^rw)};                      // R26
					d.ld    = 1'b0;
				end else if (!q.pend && !q.ack &&
					(q.bits == BITS_W'(WORD_BITS))) begin
					d.cnt = '0;
					d.st  = ST_LEAD;                             // R23
				end
			end
			ST_WAIT: begin
				d.cnt = q.cnt + 1'b1;
				if (I_SEEK_DONE) begin
					d.cnt = '0;
					d.st  = ST_LEAD;                             // R21
				end else if (q.recal &&
					(q.cnt == CNT_W'(RECAL_CYC - 1))) begin
					// Recalibrate overran its limit
					d.att = 1'b1;
					d.cnt = '0;
					d.st  = ST_LEAD;                             // R22
				end
			end
			ST_LEAD: begin
				// Attention settles before complete rises
				if (q.cnt == CNT_W'(LEAD_CYC - 1)) begin
					d.cnt  = '0;
					d.bits = '0;
					d.st   = ST_IDLE;                            // R24
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
		endcase
		d.cc = (d.st == ST_IDLE);                                // R21
	end

	// State register
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			q    <= '0;
			q.st <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// Complete and attention only speak while selected
	assign O_DRIVE_SELECTED = q.sel;
	assign O_READY          = q.rdy;
	assign O_CMD_COMPLETE   = q.cc && q.sel;
	assign O_ATTENTION      = q.att && q.sel;
	assign O_XFER_ACK       = q.ack;
	assign O_CFG_STATUS     = q.dout;
	assign O_AM_FOUND       = q.amf;
	assign O_READ_DATA      = q.rdata;
	assign O_REF_CLK_OUT    = q.refo;
	assign O_HEAD           = q.head;
	assign O_MEDIA_WR_CLK   = q.wclk;
	assign O_MEDIA_WR_DATA  = q.wdat;
	assign O_SEEK_START     = q.seek_go;
	assign O_SEEK_CYL       = q.cyl;
	assign O_RECAL_START    = q.recal_go;
	assign O_MOTOR_START    = q.motor_go;
	assign O_CMD_STROBE     = q.stb;
	assign O_CMD_WORD       = q.cmd;
	assign O_INFO_KIND      = q.kind;
	assign O_INFO_SEL       = q.isel;

endmodule : esc_cmd_port

// ---- hw/esc_pkg.sv ----
// Constants and types for the drive-side serial command port
package esc_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 4;        // 250 MHz core clock
	localparam int T_ACK_NS       = 2000;     // Typical ack answer time
	localparam int T_ATTN_LEAD_NS = 100;      // Attention before complete
	localparam int T_RECAL_MS     = 100;      // Longest recalibrate time
	localparam int ACK_CYC        = T_ACK_NS / CLK_PERIOD_NS;
	localparam int LEAD_CYC       =
		(T_ATTN_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECAL_CYC_DEF  = T_RECAL_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W          = 27;       // Shared counter width

	// Serial word layout
	localparam int WORD_BITS = 17;            // 16 data bits plus parity
	localparam int BITS_W    = 5;
	localparam int OP_HI     = 15;
	localparam int OP_LO     = 12;
	localparam int MOD_HI    = 11;
	localparam int MOD_LO    = 8;
	localparam int PAR_HI    = 11;

	// Drive ID
	localparam logic [2:0] ID_NONE = 3'h0;    // Never selects a drive

	// Opcodes
	localparam logic [3:0] OP_SEEK    = 4'h0;
	localparam logic [3:0] OP_RECAL   = 4'h1;
	localparam logic [3:0] OP_STATUS  = 4'h2;
	localparam logic [3:0] OP_CONFIG  = 4'h3;
	localparam logic [3:0] OP_HEADGRP = 4'h4;
	localparam logic [3:0] OP_CONTROL = 4'h5;
	localparam logic [3:0] OP_STROBE  = 4'h6;
	localparam logic [3:0] OP_TRACK   = 4'h7;
	localparam logic [3:0] OP_DIAG    = 4'h8;
	localparam logic [3:0] OP_BPS     = 4'h9;
	localparam logic [3:0] OP_SETCFG  = 4'hE;

	// Modifiers
	localparam logic [3:0] MOD_GENERAL   = 4'h0;  // General config / std
	localparam logic [3:0] MOD_RST_ATTN  = 4'h0;  // Reset attention
	localparam logic [3:0] MOD_START_MTR = 4'h3;  // Start spindle
	localparam logic [3:0] MOD_CFG_BADLO = 4'hA;  // Invalid config codes
	localparam logic [3:0] MOD_CFG_BADHI = 4'hE;
	localparam logic [11:0] BPS_MIN      = 12'h052; // Least bytes/sector

	// Standard status flag positions owned by this block
	localparam int STS_PARITY  = 0;
	localparam int STS_INVALID = 1;

	// Information source kinds
	localparam logic INFO_STATUS = 1'b0;
	localparam logic INFO_CONFIG = 1'b1;

	// Command state, Gray from IDLE to LEAD via WAIT or TX
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX   = 3'h1,
		ST_EXEC = 3'h3,
		ST_TX   = 3'h7,
		ST_WAIT = 3'h2,
		ST_LEAD = 3'h6
	} esc_state_t;

endpackage : esc_pkg

// ---- hw/esc_sync.sv ----
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module esc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Asynchronous in, synchronised out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	// Both stages held together
	typedef struct packed {
		logic [WIDTH-1:0] s1;   // First stage, read only by s2
		logic [WIDTH-1:0] s2;   // Second stage, safe to use
	} esc_sync_t;

	esc_sync_t q;
	esc_sync_t d;

	// Shift chain
	always_comb begin
		d    = q;
		d.s1 = i_async;
		d.s2 = q.s1;
	end

	// Stage registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_sync = q.s2;

endmodule : esc_sync

// ---- test/esc_host_model.sv ----
// Host controller model for the serial command handshake
`timescale 1ns/1ns
module esc_host_model (
	// Clock
	input  wire logic i_clk,
	// Drive answers
	input  wire logic i_ack,
	input  wire logic i_bit,
	// Host request lines
	output logic      o_req,
	output logic      o_data
);
	int tmo = 0; // Waits that ran out

	// Idle levels at time zero
	initial begin
		o_req = 1'b0;
		o_data = 1'b1;
	end

	// Bounded wait until the ack level equals v
	task automatic wait_ack(input logic v);
		int n;
		n = 0;
		while (i_ack !== v && n < 3000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 3000)
			tmo++;
	endtask : wait_ack

	// Interlocked 17-bit transfer, MSB first; reply bit taken at ack rise
	task automatic xfer(input logic [16:0] w, output logic [16:0] r);
		for (int i = 16; i >= 0; i--) begin
			o_data <= w[i];
			@(posedge i_clk);
			o_req <= 1'b1; // Data settled before the rise
			@(posedge i_clk);
			wait_ack(1'b1);
			r[i] = i_bit;
			o_req <= 1'b0;
			@(posedge i_clk);
			wait_ack(1'b0);
			o_data <= ~w[i]; // Released line shows no stale bit
			@(posedge i_clk); // Next bit drives data on a later edge
		end
	endtask : xfer
endmodule : esc_host_model

// ---- test/esc_cmd_port_asserts.sv ----
// Pin-level checks of select, handshake and completion timing
`timescale 1ns/1ns
module esc_cmd_port_asserts
	import esc_pkg::*;
#(
	parameter int RECAL_CYC = RECAL_CYC_DEF // Recalibrate limit
) (
	input wire logic       I_CLK,
	input wire logic       I_RESET_N,
	input wire logic [2:0] I_SEL,
	input wire logic [2:0] I_DRIVE_ID,
	input wire logic       I_XFER_REQ,
	input wire logic       I_SEEK_DONE,
	input wire logic       O_DRIVE_SELECTED,
	input wire logic       O_READY,
	input wire logic       O_CMD_COMPLETE,
	input wire logic       O_ATTENTION,
	input wire logic       O_XFER_ACK,
	input wire logic [3:0] O_HEAD,
	input wire logic       O_SEEK_START,
	input wire logic       O_RECAL_START
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	logic [5:0]       sel_p_q; // Select lines last cycle
	logic [2:0]       age_q;   // Cycles since select moved
	logic             seek_q;  // Seek in flight
	logic [CNT_W-1:0] rc_q;    // Recalibrate cycles so far

	// Helper counters beside the assertions
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sel_p_q <= 6'h00;
			age_q <= 3'h0;
			seek_q <= 1'b0;
			rc_q <= '0;
		end else begin
			sel_p_q <= {I_SEL, I_DRIVE_ID};
			if (sel_p_q != {I_SEL, I_DRIVE_ID})
				age_q <= 3'h0;
			else if (age_q != 3'h7)
				age_q <= age_q + 3'h1;
			seek_q <= O_SEEK_START | (seek_q & ~I_SEEK_DONE);
			if (O_RECAL_START)
				rc_q <= CNT_W'(1);
			else if (rc_q != 0 && !O_CMD_COMPLETE)
				rc_q <= rc_q + 1'b1;
			else
				rc_q <= '0;
		end
	end

	// Handshake steps
	sequence req_edge;
		$changed(I_XFER_REQ);
	endsequence
	sequence ack_match;
		O_XFER_ACK == I_XFER_REQ;
	endsequence

	sel_match_a: assert property (age_q >= 4 &&
		sel_p_q == {I_SEL, I_DRIVE_ID} |-> O_DRIVE_SELECTED ==
		(I_SEL == I_DRIVE_ID && I_DRIVE_ID != ID_NONE))
		else $error("select decode wrong");
	ready_sel_a: assert property (O_READY |-> O_DRIVE_SELECTED)
		else $error("ready without select");
	ack_equal_a: assert property ($changed(O_XFER_ACK) |-> ack_match)
		else $error("ack moved away from request");
	ack_bound_a: assert property (req_edge |-> ##[1:600] ack_match)
		else $error("ack late");
	cmd_take_a: assert property ($rose(I_XFER_REQ) && O_CMD_COMPLETE
		|-> ##[1:5] !O_CMD_COMPLETE) else $error("complete kept high");
	attn_lead_a: assert property ($rose(O_CMD_COMPLETE) && O_ATTENTION
		&& $past(O_DRIVE_SELECTED) |-> $past(O_ATTENTION, 25))
		else $error("attention lead too short");
	seek_hold_a: assert property (O_SEEK_START |=>
		(!O_CMD_COMPLETE until I_SEEK_DONE)) else $error("early complete");
	seek_done_a: assert property ($fell(seek_q) |-> ##[20:40] O_CMD_COMPLETE)
		else $error("no complete after seek");
	recal_time_a: assert property (rc_q <= RECAL_CYC + 40)
		else $error("recalibrate too long");
	head_keep_a: assert property ($changed(O_HEAD) |->
		$stable(O_CMD_COMPLETE) && $stable(O_READY))
		else $error("head change moved status");
endmodule : esc_cmd_port_asserts

bind esc_cmd_port esc_cmd_port_asserts #(.RECAL_CYC(RECAL_CYC)) u_chk (
	.I_CLK, .I_RESET_N, .I_SEL, .I_DRIVE_ID, .I_XFER_REQ, .I_SEEK_DONE,
	.O_DRIVE_SELECTED, .O_READY, .O_CMD_COMPLETE, .O_ATTENTION,
	.O_XFER_ACK, .O_HEAD, .O_SEEK_START, .O_RECAL_START);

// ---- test/esc_cmd_port_test.sv ----
// Self-checking bench for the drive-side command port
`timescale 1ns/1ns
module esc_cmd_port_test
	import esc_pkg::*;
;
	localparam int RCYC = 200; // Short recalibrate limit
	logic clk = 0, rst_n = 0, lclk = 0, mon = 0;
	logic [2:0] sel, id;
	logic [3:0] head, oh, isel, op;
	logic rg, wg, ame, amd, rdy, rdat, wdat, sdone, req, cdat;
	logic dsel, ordy, cc, attn, ack, cfg, amf, rdo, refo, wco, wdo;
	logic sks, rcs, mst, stb, kind;
	logic [11:0] cyl, cy;
	logic [15:0] info, cw, sw;
	logic [16:0] rep;
	logic [7:0] hist[$]; // Expected data path, oldest first
	logic [3:0] bad[6] = '{4'h4, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
	int err_count = 0, checks = 0, seek_n = 0, rec_n = 0, stb_n = 0, n;

	// Core clock and an unrelated link clock
	always #2 clk = ~clk;
	initial begin
		#5;
		forever #16 lclk = ~lclk;
	end

	esc_cmd_port #(.RECAL_CYC(RCYC)) u_dut (
		.I_CLK(clk), .I_RESET_N(rst_n), .I_SEL(sel), .I_HEAD(head),
		.I_DRIVE_ID(id), .I_XFER_REQ(req), .I_CMD_DATA(cdat),
		.I_READ_GATE(rg), .I_WRITE_GATE(wg), .I_AM_ENABLE(ame),
		.I_WRITE_CLK(lclk & wg), .I_WRITE_DATA(wdat), .I_READ_CLK(~lclk),
		.I_READ_DATA(rdat), .I_REF_CLK(lclk), .I_AM_DETECT(amd),
		.I_READY(rdy), .I_MOTOR_OPT(1'b0), .I_FAULT(1'b0),
		.I_SEEK_DONE(sdone), .I_INFO_WORD(info), .O_DRIVE_SELECTED(dsel),
		.O_READY(ordy), .O_CMD_COMPLETE(cc), .O_ATTENTION(attn),
		.O_XFER_ACK(ack), .O_CFG_STATUS(cfg), .O_AM_FOUND(amf),
		.O_READ_DATA(rdo), .O_REF_CLK_OUT(refo), .O_HEAD(oh),
		.O_MEDIA_WR_CLK(wco), .O_MEDIA_WR_DATA(wdo), .O_SEEK_START(sks),
		.O_SEEK_CYL(cyl), .O_RECAL_START(rcs), .O_MOTOR_START(mst),
		.O_CMD_STROBE(stb), .O_CMD_WORD(cw), .O_INFO_KIND(kind),
		.O_INFO_SEL(isel));

	esc_host_model u_host (.i_clk(clk), .i_ack(ack), .i_bit(cfg),
		.o_req(req), .o_data(cdat));

	// Bit and word comparisons
	task automatic cmp_bit(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : cmp_bit
	task automatic cmp_word(input logic [16:0] g, input logic [16:0] e,
		input string m);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : cmp_word

	// Verdict and end of run
	task automatic test_done;
		err_count += u_host.tmo;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// Bounded wait for command complete
	task automatic wait_cc(input int lim);
		n = 0;
		while (cc !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			err_count++;
			$display("wrong value at %0t: no complete", $time);
			test_done();
		end
	endtask : wait_cc

	// Command word with parity, only once complete is seen
	task automatic send(input logic [15:0] w);
		wait_cc(2000);
		u_host.xfer({w, ~^w}, rep);
		if (u_host.tmo != 0)
			test_done();
	endtask : send

	// Pulse counters for mechanics requests
	always @(posedge clk) begin
		if (sks === 1'b1)
			seek_n++;
		if (rcs === 1'b1)
			rec_n++;
		if (stb === 1'b1)
			stb_n++;
		if (mst === 1'b1)
			stb_n++;
	end

	// Data path model, outputs three clocks behind the pins
	always @(posedge clk) begin
		logic s;
		logic [7:0] e;
		s = (sel == id);
		if (mon) begin
			hist.push_back({s & rg & rdat, (s & rg) ? ~lclk : lclk,
				s & wg & lclk, s & wg & wdat, head});
			if (hist.size() > 3) begin
				e = hist.pop_front();
				cmp_bit(rdo, e[7], "read data");
				cmp_bit(refo, e[6], "reference swap");
				cmp_bit(wco, e[5], "write clock");
				cmp_bit(wdo, e[4], "write data");
				cmp_word({13'h0, oh}, {13'h0, e[3:0]}, "head");
			end
		end
	end

	// Main sequence
	initial begin
		void'($urandom(32'h50AFD91C));
		{sel, head, rg, wg, ame, amd, rdat, wdat, sdone} = '0;
		rdy = 1'b1;
		id = 3'($urandom_range(7, 1));
		info = 16'($urandom);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (250) @(posedge clk);
		sel <= 3'(id % 3'h7) + 3'h1;
		repeat (4) @(posedge clk);
		cmp_bit(dsel, 1'b0, "other id");
		sel <= ID_NONE;
		repeat (4) @(posedge clk);
		cmp_bit(dsel, 1'b0, "zero id");
		sel <= id;
		repeat (4) @(posedge clk);
		cmp_bit(dsel, 1'b1, "selected");
		cmp_bit(ordy, 1'b1, "ready");
		cmp_bit(cc, 1'b1, "idle complete");
		mon <= 1'b1;
		for (int i = 0; i < 1800; i++) begin
			@(posedge clk);
			rdat <= 1'($urandom);
			wdat <= 1'($urandom);
			if (i < 200) begin
				rg <= 1'($urandom);
				head <= 4'($urandom);
			end else begin
				rg <= 1'b0;
				wg <= (i > 1500) ? 1'($urandom) : 1'b0;
			end
		end
		wg <= 1'b0;
		repeat (300) @(posedge clk);
		mon <= 1'b0;
		ame <= 1'b1;
		repeat (8) @(posedge clk);
		cmp_bit(amf, 1'b0, "mark early");
		amd <= 1'b1;
		repeat (8) @(posedge clk);
		cmp_bit(amf, 1'b1, "mark found");
		amd <= 1'b0;
		ame <= 1'b0;
		repeat (8) @(posedge clk);
		cmp_bit(amf, 1'b0, "mark cleared");
		cy = 12'($urandom);
		send({OP_SEEK, cy});
		for (n = 0; n < 100 && seek_n == 0; n++)
			@(posedge clk);
		cmp_word({5'h0, cyl}, {5'h0, cy}, "cylinder");
		cmp_bit(seek_n == 1, 1'b1, "seek start");
		cmp_word({1'b0, cw}, {1'b0, OP_SEEK, cy}, "command word");
		repeat (100) @(posedge clk);
		cmp_bit(cc, 1'b0, "seek busy");
		sdone <= 1'b1;
		@(posedge clk);
		sdone <= 1'b0;
		wait_cc(100);
		cmp_bit(attn, 1'b0, "seek clean");
		send({OP_RECAL, 12'h000});
		wait_cc(RCYC + 100);
		cmp_bit(attn, 1'b1, "recal timeout");
		cmp_bit(rec_n == 1, 1'b1, "recal start");
		op = bad[$urandom_range(5, 0)];
		send({op, 12'($urandom)});
		wait_cc(100);
		cmp_bit(stb_n == 0 && seek_n == 1, 1'b1, "not run");
		send({OP_STATUS, MOD_GENERAL, 8'h00});
		u_host.xfer(17'h00000, rep);
		sw = info | 16'h0002;
		cmp_word(rep, {sw, ~^sw}, "status word");
		cmp_bit(kind, INFO_STATUS, "status kind");
		cmp_word({13'h0, isel}, {13'h0, MOD_GENERAL}, "info select");
		wait_cc(100);
		test_done();
	end
endmodule : esc_cmd_port_test
